// >>> rtl/lock_detect.sv
// digital lock detector with its loop configuration fields, behind an AXI4-Lite register slave
// assumes ref_edge_in and fb_edge_in are asynchronous pins; edges must be slower than 3 aclk cycles
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module lock_detect (
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic ref_edge_in, // reference path into phase detector
  input wire logic fb_edge_in, // feedback path into phase detector
  output logic digital_lock_flag, // lock flag
  output logic dc_offset_en, // reference dc offset enable
  output logic [7:0] abl_width_tenth_ns, // antibacklash width, 0.1 ns units
  output logic irq // level interrupt
);

  function automatic logic [7:0] lock_target(input logic [1:0] sel);
    unique case (sel)
      2'b00: lock_target = lock_detect_pkg::LOCK_CNT_C0;
      2'b01: lock_target = lock_detect_pkg::LOCK_CNT_C1;
      2'b10: lock_target = lock_detect_pkg::LOCK_CNT_C2;
      2'b11: lock_target = lock_detect_pkg::LOCK_CNT_C3;
    endcase
  endfunction : lock_target

  lock_detect_pkg::lock_cfg_t cfg_reg;
  logic [1:0] abl_reg, irq_sts_reg, irq_mask_reg, lock_events;
  logic lock_reg;
  logic [7:0] run_cnt_reg, diff_reg, aw_addr_reg, w_data_reg;
  lock_detect_pkg::meas_state_t meas_reg;
  logic [2:0] ref_sync_reg, fb_sync_reg;
  logic ref_rise, fb_rise, cyc_done, in_win, beyond_loss;
  logic [7:0] cyc_diff, lock_win_cyc, target;
  logic aw_held_reg, w_held_reg, w_strb0_reg;
  logic do_write, rd_take, rd_clear;

  // pins pass two flops; bit 2 is the edge history, bit 0 only feeds bit 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_sync_reg <= 3'h0;
      fb_sync_reg <= 3'h0;
    end else begin
      ref_sync_reg <= {ref_sync_reg[1:0], ref_edge_in};
      fb_sync_reg <= {fb_sync_reg[1:0], fb_edge_in};
    end
  end
  assign ref_rise = ref_sync_reg[1] & ~ref_sync_reg[2];
  assign fb_rise = fb_sync_reg[1] & ~fb_sync_reg[2];

  // measure the edge-to-edge difference; a repeated edge on one path ends the cycle as far out
  always_comb begin
    cyc_done = 1'b0;
    cyc_diff = diff_reg;
    unique case (meas_reg)
      lock_detect_pkg::M_IDLE: begin
        cyc_done = ref_rise & fb_rise;
        cyc_diff = 8'h00;
      end
      lock_detect_pkg::M_WAIT_FB: begin
        cyc_done = fb_rise | ref_rise;
        cyc_diff = fb_rise ? diff_reg : 8'hFF;
      end
      lock_detect_pkg::M_WAIT_REF: begin
        cyc_done = ref_rise | fb_rise;
        cyc_diff = ref_rise ? diff_reg : 8'hFF;
      end
      default: begin
        cyc_done = 1'b0;
        cyc_diff = 8'hFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_reg <= lock_detect_pkg::M_IDLE;
      diff_reg <= 8'h00;
    end else if (meas_reg == lock_detect_pkg::M_IDLE) begin
      diff_reg <= 8'h01;
      if (ref_rise && !fb_rise)
        meas_reg <= lock_detect_pkg::M_WAIT_FB;
      else if (fb_rise && !ref_rise)
        meas_reg <= lock_detect_pkg::M_WAIT_REF;
    end else if (cyc_done) begin
      meas_reg <= lock_detect_pkg::M_IDLE;
      diff_reg <= 8'h00;
    end else if (diff_reg != 8'hFF) begin
      diff_reg <= diff_reg + 8'h01;
    end
  end

  assign lock_win_cyc = cfg_reg.win_sel ? 8'(lock_detect_pkg::LOCK_WIN_ALT_CYC)
                                        : 8'(lock_detect_pkg::LOCK_WIN_DEF_CYC);
  assign target = lock_target(cfg_reg.lock_cnt_sel);
  assign in_win = cyc_diff < lock_win_cyc;
  assign beyond_loss = cyc_diff > 8'(lock_detect_pkg::UNLOCK_WIN_CYC);

  // lock qualification with hysteresis
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_reg <= 1'b0;
      run_cnt_reg <= 8'h00;
    end else if (cfg_reg.ld_disable) begin
      lock_reg <= 1'b0;
      run_cnt_reg <= 8'h00;
    end else if (cyc_done) begin
      if (!lock_reg) begin
        if (!in_win) begin
          run_cnt_reg <= 8'h00;
        end else if (run_cnt_reg + 8'h01 >= target) begin
          lock_reg <= 1'b1;
          run_cnt_reg <= 8'h00;
        end else begin
          run_cnt_reg <= run_cnt_reg + 8'h01;
        end
      end else if (beyond_loss) begin
        lock_reg <= 1'b0;
      end
    end
  end
  assign digital_lock_flag = lock_reg;

  // AXI4-Lite write: address and data taken in either order, then one response
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lock_detect_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        unique case (aw_addr_reg)
          lock_detect_pkg::ADDR_LOCK_CFG, lock_detect_pkg::ADDR_ABL_CFG, lock_detect_pkg::ADDR_STATUS,
          lock_detect_pkg::ADDR_IRQ_STS, lock_detect_pkg::ADDR_IRQ_MASK: s_axi_bresp <= lock_detect_pkg::RESP_OKAY;
          default: s_axi_bresp <= lock_detect_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; status and irq status ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= lock_detect_pkg::LOCK_CFG_RST;
      abl_reg <= lock_detect_pkg::ABL_CFG_RST[1:0];
      irq_mask_reg <= lock_detect_pkg::IRQ_RST;
    end else if (do_write && w_strb0_reg) begin
      if (aw_addr_reg == lock_detect_pkg::ADDR_LOCK_CFG)
        cfg_reg <= w_data_reg;
      if (aw_addr_reg == lock_detect_pkg::ADDR_ABL_CFG)
        abl_reg <= w_data_reg[1:0];
      if (aw_addr_reg == lock_detect_pkg::ADDR_IRQ_MASK)
        irq_mask_reg <= w_data_reg[1:0];
    end
  end

  // configuration outputs from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dc_offset_en <= 1'b0;
      abl_width_tenth_ns <= lock_detect_pkg::ABL_W_00;
    end else begin
      dc_offset_en <= cfg_reg.dc_offset_en;
      unique case (abl_reg)
        2'b00: abl_width_tenth_ns <= lock_detect_pkg::ABL_W_00;
        2'b01: abl_width_tenth_ns <= lock_detect_pkg::ABL_W_01;
        2'b10: abl_width_tenth_ns <= lock_detect_pkg::ABL_W_10;
        2'b11: abl_width_tenth_ns <= lock_detect_pkg::ABL_W_11;
      endcase
    end
  end

  // read channel: one outstanding read, answered the cycle after it is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_clear = rd_take && ({s_axi_araddr[7:2], 2'b00} == lock_detect_pkg::ADDR_IRQ_STS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lock_detect_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= lock_detect_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        lock_detect_pkg::ADDR_LOCK_CFG: s_axi_rdata <= {24'h00_0000, cfg_reg};
        lock_detect_pkg::ADDR_ABL_CFG: s_axi_rdata <= {30'h0000_0000, abl_reg};
        lock_detect_pkg::ADDR_STATUS: s_axi_rdata <= {16'h0000, run_cnt_reg, 7'h00, lock_reg};
        lock_detect_pkg::ADDR_IRQ_STS: s_axi_rdata <= {30'h0000_0000, irq_sts_reg};
        lock_detect_pkg::ADDR_IRQ_MASK: s_axi_rdata <= {30'h0000_0000, irq_mask_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= lock_detect_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // sticky events, cleared by reading; a new event in the clearing cycle survives
  always_comb begin
    lock_events = 2'b00;
    lock_events[lock_detect_pkg::IRQ_LOCK_GAINED] = cyc_done && !cfg_reg.ld_disable && !lock_reg && in_win
                                                    && (run_cnt_reg + 8'h01 >= target);
    lock_events[lock_detect_pkg::IRQ_LOCK_LOST] = lock_reg && (cfg_reg.ld_disable || (cyc_done && beyond_loss));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_sts_reg <= lock_detect_pkg::IRQ_RST;
    else
      irq_sts_reg <= (rd_clear ? 2'b00 : irq_sts_reg) | lock_events;
  end
  assign irq = |(irq_sts_reg & irq_mask_reg);

  a_lock_after_run: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(lock_reg) |-> $past(run_cnt_reg) + 8'h01 >= $past(target) && $past(cyc_done) && $past(in_win))
    else $error("lock flag rose without a full run");
  a_lock_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_reg && !cfg_reg.ld_disable && !(cyc_done && beyond_loss) |=> lock_reg)
    else $error("lock flag dropped inside the loss threshold");
  a_loss_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_reg && cyc_done && beyond_loss |=> !lock_reg)
    else $error("lock flag kept beyond the loss threshold");
  a_default_window: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_reg.win_sel && cyc_done |-> in_win == (cyc_diff == 8'h00
      || (int'(cyc_diff) + 1) * lock_detect_pkg::CLK_PERIOD_PS <= lock_detect_pkg::LOCK_WIN_DEF_PS))
    else $error("default lock window misapplied");
  a_abl_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    abl_reg == 2'b10 ##1 abl_reg == 2'b10 |-> abl_width_tenth_ns == lock_detect_pkg::ABL_W_10)
    else $error("antibacklash width wrong for code 10");
  a_dc_offset: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && w_strb0_reg && aw_addr_reg == lock_detect_pkg::ADDR_LOCK_CFG |-> ##2 dc_offset_en == $past(w_data_reg[7], 2))
    else $error("dc offset enable does not follow bit 7");
  a_disable_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_reg.ld_disable |=> !lock_reg && run_cnt_reg == 8'h00)
    else $error("lock detection active while disabled");
  a_miss_restarts: assert property (@(posedge aclk) disable iff (!aresetn)
    !lock_reg && !cfg_reg.ld_disable && cyc_done && !in_win |=> run_cnt_reg == 8'h00)
    else $error("consecutive count kept after a miss");

  c_lock_gained: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lock_reg));
  c_lock_lost: cover property (@(posedge aclk) disable iff (!aresetn) $fell(lock_reg) && !cfg_reg.ld_disable);
  c_irq_raised: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_run_broken: cover property (@(posedge aclk) disable iff (!aresetn) run_cnt_reg > 8'h01 ##1 run_cnt_reg == 8'h00 && !lock_reg);

endmodule : lock_detect

`default_nettype wire

// >>> rtl/lock_detect_pkg.sv
// package for the digital lock detector: register map, field layouts, reset values and timing figures
// assumes a single 100 MHz register/detector clock; times are kept in picoseconds
package lock_detect_pkg;

  // register byte addresses (32-bit aligned words)
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h18;
  localparam logic [7:0] ADDR_ABL_CFG = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

  // lock detect and reference configuration, bit 7 down to bit 0
  typedef struct packed {
    logic dc_offset_en;      // bit 7
    logic [1:0] lock_cnt_sel; // bits 6:5
    logic win_sel;           // bit 4
    logic ld_disable;        // bit 3
    logic [1:0] cal_div;     // bits 2:1, stored only
    logic cal_now;           // bit 0, stored only
  } lock_cfg_t;

  localparam logic [7:0] LOCK_CFG_RST = 8'h06;
  localparam logic [7:0] ABL_CFG_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  // interrupt status / mask bit positions
  localparam int IRQ_LOCK_GAINED = 0;
  localparam int IRQ_LOCK_LOST = 1;

  // lock counter codes map to 5, 16, 64, 255 detector cycles
  localparam logic [7:0] LOCK_CNT_C0 = 8'h05;
  localparam logic [7:0] LOCK_CNT_C1 = 8'h10;
  localparam logic [7:0] LOCK_CNT_C2 = 8'h40;
  localparam logic [7:0] LOCK_CNT_C3 = 8'hFF;

  // antibacklash width in tenths of a ns per code
  localparam logic [7:0] ABL_W_00 = 8'h1D; // 2.9 ns
  localparam logic [7:0] ABL_W_01 = 8'h0D; // 1.3 ns
  localparam logic [7:0] ABL_W_10 = 8'h3C; // 6.0 ns
  localparam logic [7:0] ABL_W_11 = 8'h1D; // 2.9 ns

  // timing: clock period and detection windows
  localparam int CLK_PERIOD_PS = 10000;
  localparam int LOCK_WIN_DEF_PS = 3500;
  localparam int LOCK_WIN_ALT_PS = 7500;
  localparam int UNLOCK_WIN_PS = 20000;
  // longest times round down, never below one cycle
  localparam int LOCK_WIN_DEF_CYC = (LOCK_WIN_DEF_PS / CLK_PERIOD_PS) < 1 ? 1 : (LOCK_WIN_DEF_PS / CLK_PERIOD_PS);
  localparam int LOCK_WIN_ALT_CYC = (LOCK_WIN_ALT_PS / CLK_PERIOD_PS) < 1 ? 1 : (LOCK_WIN_ALT_PS / CLK_PERIOD_PS);
  localparam int UNLOCK_WIN_CYC = (UNLOCK_WIN_PS / CLK_PERIOD_PS) < 1 ? 1 : (UNLOCK_WIN_PS / CLK_PERIOD_PS);

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {M_IDLE, M_WAIT_REF, M_WAIT_FB} meas_state_t;

endpackage : lock_detect_pkg

// >>> bench/edge_source.sv
// behavioural source of the reference and feedback edges into the phase detector
// assumes aclk from the bench; run and skew change just after a rising edge, skew 0 to 3
`timescale 1ns/10ps
`default_nettype none
module edge_source (
  input wire logic aclk, // detector clock
  input wire logic run, // produce edges while high
  input wire logic [2:0] skew, // feedback lag in aclk cycles
  output logic ref_edge, // reference path
  output logic fb_edge // feedback path
);
  logic [2:0] phase_reg;
  always_ff @(posedge aclk) begin
    if (!run) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_reg + 3'h1;
    end
  end
  // 8 cycle period keeps each pin's edges far apart; both paths stand low between runs
  assign ref_edge = run && (phase_reg < 3'h4);
  assign fb_edge = run && (phase_reg >= skew) && ({1'b0, phase_reg} < ({1'b0, skew} + 4'h4));
endmodule : edge_source
`default_nettype wire

// >>> bench/test_lock_detect.sv
// top-level bench for the lock detector: register map, lock counting, hysteresis, disable, interrupts
// assumes edge_source drives both detector pins and one 100 MHz clock runs everything
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_lock_detect;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
  logic awready, wready, bvalid, arready, rvalid, ref_edge, fb_edge, flag, dc_off, irq;
  logic [7:0] awaddr, araddr, abl;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] skew;
  int error_cnt, tests_run;

  lock_detect dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_edge_in(ref_edge),
    .fb_edge_in(fb_edge), .digital_lock_flag(flag), .dc_offset_en(dc_off), .abl_width_tenth_ns(abl),
    .irq(irq));
  edge_source src_u (.aclk(aclk), .run(run), .skew(skew), .ref_edge(ref_edge), .fb_edge(fb_edge));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    run <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // address and data offered together; each released at its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      `CHK(1'b0, 1'b1)
      close_out();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (k == 50) begin
      `CHK(1'b0, 1'b1)
      close_out();
    end
  endtask : axi_rd

  task automatic t_regs();
    logic [7:0] exp_w [4];
    int i;
    exp_w = '{8'h1D, 8'h0D, 8'h3C, 8'h1D};
    do_reset();
    @(posedge aclk);
    #1;
    `CHK(abl, 8'h1D)
    `CHK(dc_off, 1'b0)
    axi_rd(8'h18, rd, resp);
    `CHK(rd, 32'h0000_0006)
    for (i = 0; i < 4; i++) begin
      axi_wr(8'h1C, 32'(i), resp);
      `CHK(resp, 2'b00)
      repeat (2) @(posedge aclk);
      #1;
      `CHK(abl, exp_w[i])
    end
    axi_wr(8'h18, 32'h0000_0086, resp);
    repeat (2) @(posedge aclk);
    #1;
    `CHK(dc_off, 1'b1)
    axi_rd(8'h18, rd, resp);
    `CHK(rd, 32'h0000_0086)
    // unmapped word: write refused, read gives zero
    axi_wr(8'h40, 32'h0000_00FF, resp);
    `CHK(resp, 2'b10)
    axi_rd(8'h40, rd, resp);
    `CHK(resp, 2'b10)
    `CHK(rd, 32'h0000_0000)
    $display("done: register map");
  endtask : t_regs

  // mask stays clear here, so the gained event must not reach irq
  task automatic t_count(input logic [1:0] code, input int n);
    do_reset();
    axi_wr(8'h18, {24'h0, 1'b0, code, 5'h06}, resp);
    @(posedge aclk);
    run <= 1'b1;
    skew <= 3'h0;
    repeat (8 * (n - 1)) @(posedge aclk);
    #1;
    `CHK(flag, 1'b0)
    repeat (8) @(posedge aclk);
    #1;
    `CHK(flag, 1'b1)
    `CHK(irq, 1'b0)
    axi_rd(8'h20, rd, resp);
    `CHK(rd, 32'h0000_0001)
    axi_rd(8'h24, rd, resp);
    `CHK(rd, 32'h0000_0001)
    $display("done: lock count %0d", n);
  endtask : t_count

  // four good cycles, one 10 ns late, then the full count must start over
  task automatic t_restart();
    do_reset();
    @(posedge aclk);
    run <= 1'b1;
    skew <= 3'h0;
    repeat (32) @(posedge aclk);
    skew <= 3'h1;
    repeat (8) @(posedge aclk);
    skew <= 3'h0;
    repeat (32) @(posedge aclk);
    #1;
    `CHK(flag, 1'b0)
    repeat (8) @(posedge aclk);
    #1;
    `CHK(flag, 1'b1)
    $display("done: count restart");
  endtask : t_restart

  task automatic t_hyst();
    do_reset();
    axi_wr(8'h28, 32'h0000_0003, resp);
    @(posedge aclk);
    run <= 1'b1;
    skew <= 3'h0;
    repeat (48) @(posedge aclk);
    skew <= 3'h2;
    #1;
    `CHK(flag, 1'b1)
    `CHK(irq, 1'b1)
    repeat (32) @(posedge aclk);
    skew <= 3'h3;
    #1;
    `CHK(flag, 1'b1)
    repeat (16) @(posedge aclk);
    #1;
    `CHK(flag, 1'b0)
    axi_rd(8'h24, rd, resp);
    `CHK(rd, 32'h0000_0003)
    @(posedge aclk);
    #1;
    `CHK(irq, 1'b0)
    $display("done: hysteresis and interrupt");
  endtask : t_hyst

  task automatic t_disable();
    do_reset();
    axi_wr(8'h18, 32'h0000_000E, resp);
    @(posedge aclk);
    run <= 1'b1;
    skew <= 3'h0;
    repeat (64) @(posedge aclk);
    #1;
    `CHK(flag, 1'b0)
    // re-enable with the alternate window select; both windows round to one cycle at this clock
    axi_wr(8'h18, 32'h0000_0016, resp);
    repeat (56) @(posedge aclk);
    #1;
    `CHK(flag, 1'b1)
    axi_wr(8'h18, 32'h0000_000E, resp);
    repeat (2) @(posedge aclk);
    #1;
    `CHK(flag, 1'b0)
    $display("done: detector disable");
  endtask : t_disable

  initial begin
    error_cnt = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, run} = '0;
    {awaddr, araddr, wdata, wstrb, skew} = '0;
    t_regs();
    t_count(2'h0, 5);
    t_count(2'h1, 16);
    t_count(2'h2, 64);
    t_count(2'h3, 255);
    t_restart();
    t_hyst();
    t_disable();
    close_out();
  end
endmodule : test_lock_detect
`default_nettype wire
